// ---- verilog/isb_pkg.sv ----
// shared constants and types for the two-wire slave bridge.
// assumes one 125 MHz clock; configuration arrives already decoded from
// the nonvolatile store as a packed struct.
package isb_pkg;
  // system clock
  localparam int unsigned CLK_HZ = 125_000_000;
  // nominal reference rates; the divider makes 62.5/31.25/12.5/6.25 MHz from them
  localparam int unsigned REF48_HZ = 48_000_000;
  localparam int unsigned REF24_HZ = 24_000_000;
  localparam int unsigned REF12_HZ = 12_000_000;
  localparam int unsigned REF6_HZ = 6_000_000;
  // half periods in clk cycles, rounded down, never below one
  localparam logic [7:0] HALF48 = 8'(CLK_HZ / (2 * REF48_HZ));
  localparam logic [7:0] HALF24 = 8'(CLK_HZ / (2 * REF24_HZ));
  localparam logic [7:0] HALF12 = 8'(CLK_HZ / (2 * REF12_HZ));
  localparam logic [7:0] HALF6 = 8'(CLK_HZ / (2 * REF6_HZ));
  // buffer depth in bytes, both directions
  localparam int unsigned BUF_DEPTH = 512;
  // byte returned when the master reads an empty buffer
  localparam logic [7:0] IDLE_BYTE = 8'hFF;
  // reset values of the pin filters: rst pin, data, clock idle high
  localparam logic [2:0] PIN_IDLE = 3'h7;

  // operating mode of the two bus lines
  typedef enum logic [1:0] {
    ISB_MODE_I2C = 2'b00,
    ISB_MODE_ASYNC_BB = 2'b01,
    ISB_MODE_SYNC_BB = 2'b10
  } isb_mode_t;

  // function of the auxiliary pin
  typedef enum logic [2:0] {
    ISB_AUX_TRISTATE = 3'b000,
    ISB_AUX_DRIVE1 = 3'b001,
    ISB_AUX_DRIVE0 = 3'b010,
    ISB_AUX_CLK = 3'b011,
    ISB_AUX_BB_WR_N = 3'b100,
    ISB_AUX_BB_RD_N = 3'b101,
    ISB_AUX_TXE_N = 3'b110,
    ISB_AUX_RXF_N = 3'b111
  } isb_aux_t;

  // settings held in the nonvolatile configuration memory
  typedef struct packed {
    isb_mode_t mode;
    logic [6:0] slave_addr;
    logic [6:0] nvm_addr;
    isb_aux_t aux_func;
    logic [1:0] aux_drive;
    logic [1:0] clk_sel;
    logic [1:0] bb_dir;
    logic [15:0] bb_div;
  } isb_cfg_t;
endpackage : isb_pkg

// ---- verilog/isb_bridge.sv ----
// two-wire slave bridge: bus slave, bit-bang port, aux pin, two buffers.
// assumes clk_in at 125 MHz, host-side streams on the same clock, and
// bus lines that arrive asynchronously through open-drain pads.
//
// How it works
// - slave only, drives clock only as a bit-bang port pin, 3.4 Mbit/s
// - address match: ack low, then receive/transmit
// - all bytes shift msb first
// - detect start and stop on data edges
// - acknowledge every byte the master writes, except when the buffer is full
// - repeated start reopens the address phase
// - host out bytes queue in 512-byte buffer
// - received bytes queue in 512-byte buffer
// - bit-bang: bytes paced onto 2-bit port
// - async bit-bang shows read/write strobes on aux
// - sync bit-bang samples pins only on writes
// - 125 MHz logic, 62.5/31.25/12.5/6.25 MHz references derived
// - reset at power-up and on reset pin
// - one aux pin, function and drive configured
// - config memory writable over the serial bus
// - clock line is never stretched
// - aux pin gives active-low buffer status flags
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// byte buffer with a registered read port
module isb_fifo #(
  parameter int unsigned DEPTH = 512
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // filling side
  input wire logic wr_valid_in,
  input wire logic [7:0] wr_data_in,
  output logic wr_ready_out,
  // draining side
  output logic rd_valid_out,
  output logic [7:0] rd_data_out,
  input wire logic rd_ready_in
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [7:0] mem [DEPTH]; // byte storage
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d; // pointers
  logic [AW:0] cnt_q, cnt_d; // fill level
  logic push, pop;

  // next pointers; a write landing on the next read slot is bypassed,
  // because the array still holds the old byte in that cycle
  always_comb begin
    push = wr_valid_in & wr_ready_out;
    pop = rd_valid_out & rd_ready_in;
    wr_d = wr_q + AW'(push);
    rd_d = rd_q + AW'(pop);
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  // register state and read port
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_q] <= wr_data_in;
    end
    if (rst_in) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      wr_ready_out <= 1'b0;
      rd_valid_out <= 1'b0;
      rd_data_out <= 8'h00;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      wr_ready_out <= (cnt_d != (AW+1)'(DEPTH));
      rd_valid_out <= (cnt_d != '0);
      rd_data_out <= (push && wr_q == rd_d) ? wr_data_in : mem[rd_d];
    end
  end
endmodule : isb_fifo

////////////////////////////////////////////////////////////////////////////////
module isb_bridge (
  // clock and resets
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic rst_n_pin_in,
  // configuration from the nonvolatile store
  input wire isb_pkg::isb_cfg_t cfg_in,
  // serial bus pins (open drain, port pins in bit-bang)
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_out,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // auxiliary control pin
  output logic aux_control_pin_out,
  output logic aux_control_pin_oe_out,
  output logic [1:0] aux_drive_out,
  // host out endpoint stream
  input wire logic host_out_valid_in,
  input wire logic [7:0] host_out_data_in,
  output logic host_out_ready_out,
  // host in endpoint stream
  output logic host_in_valid_out,
  output logic [7:0] host_in_data_out,
  input wire logic host_in_ready_in,
  // configuration memory writes from the bus
  output logic nvm_wr_valid_out,
  output logic [7:0] nvm_wr_data_out
);
  import isb_pkg::*;

  typedef enum logic [2:0] {
    ISB_ST_IDLE = 3'b000,
    ISB_ST_ADDR = 3'b001,
    ISB_ST_ADDR_ACK = 3'b010,
    ISB_ST_WR_DATA = 3'b011,
    ISB_ST_WR_ACK = 3'b100,
    ISB_ST_RD_DATA = 3'b101,
    ISB_ST_RD_ACK = 3'b110
  } isb_state_t;

  //////////////////////////////////////////////////////////////////////////////
  // pin filters: three flops, a change counts once stages two and three agree
  logic [2:0] ff1_q, ff2_q, ff3_q, pin_q, pin_d; // {rst_n, sda, scl}
  logic [1:0] prev_q; // last filtered {sda, scl}
  logic rst_all; // internal reset

  always_comb begin
    pin_d = (~(ff2_q ^ ff3_q) & ff3_q) | ((ff2_q ^ ff3_q) & pin_q);
  end

  // only the power-on/system reset clears the filters themselves
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ff1_q <= PIN_IDLE;
      ff2_q <= PIN_IDLE;
      ff3_q <= PIN_IDLE;
      pin_q <= PIN_IDLE;
      prev_q <= PIN_IDLE[1:0];
    end else begin
      ff1_q <= {rst_n_pin_in, sda_in, scl_in};
      ff2_q <= ff1_q;
      ff3_q <= ff2_q;
      pin_q <= pin_d;
      prev_q <= pin_q[1:0];
    end
  end

  assign rst_all = rst_in | ~pin_q[2];

  //////////////////////////////////////////////////////////////////////////////
  // the two buffers
  logic rx_valid, rx_ready, tx_ready, tx_push;
  logic [7:0] rx_data, tx_data;
  logic i2c_pop, bb_pop, i2c_push, bb_push;
  logic [7:0] i2c_byte, bb_byte;
  logic i2c_mode;

  assign i2c_mode = (cfg_in.mode == ISB_MODE_I2C);
  assign rx_ready = i2c_pop | bb_pop;
  assign tx_push = i2c_push | bb_push;
  assign tx_data = i2c_mode ? i2c_byte : bb_byte;

  // host out toward the bus
  isb_fifo #(.DEPTH(BUF_DEPTH)) u_rx_buf (
    .clk_in(clk_in),
    .rst_in(rst_all),
    .wr_valid_in(host_out_valid_in),
    .wr_data_in(host_out_data_in),
    .wr_ready_out(host_out_ready_out),
    .rd_valid_out(rx_valid),
    .rd_data_out(rx_data),
    .rd_ready_in(rx_ready)
  );

  // bus toward host in
  isb_fifo #(.DEPTH(BUF_DEPTH)) u_tx_buf (
    .clk_in(clk_in),
    .rst_in(rst_all),
    .wr_valid_in(tx_push),
    .wr_data_in(tx_data),
    .wr_ready_out(tx_ready),
    .rd_valid_out(host_in_valid_out),
    .rd_data_out(host_in_data_out),
    .rd_ready_in(host_in_ready_in)
  );

  //////////////////////////////////////////////////////////////////////////////
  // serial slave; works on filtered edges, so no stretching is ever needed
  isb_state_t st_q, st_d;
  logic [3:0] cnt_q, cnt_d; // bits moved in this byte
  logic [7:0] sreg_q, sreg_d; // shift register, msb on the wire
  logic rw_q, rw_d, nvm_q, nvm_d, ack_q, ack_d;
  logic drv_q, drv_d; // pull data low
  logic nvm_v_d;
  logic [7:0] nvm_data_d, next_byte;
  logic scl_r, scl_f, start_c, stop_c;

  always_comb begin
    scl_r = pin_q[0] & ~prev_q[0];
    scl_f = ~pin_q[0] & prev_q[0];
    start_c = pin_q[0] & prev_q[0] & prev_q[1] & ~pin_q[1];
    stop_c = pin_q[0] & prev_q[0] & ~prev_q[1] & pin_q[1];
    // the config memory address reads back idle bytes
    next_byte = (rx_valid & ~nvm_q) ? rx_data : IDLE_BYTE;
    st_d = st_q;
    cnt_d = cnt_q;
    sreg_d = sreg_q;
    rw_d = rw_q;
    nvm_d = nvm_q;
    ack_d = ack_q;
    drv_d = drv_q;
    nvm_v_d = 1'b0;
    nvm_data_d = nvm_wr_data_out;
    i2c_pop = 1'b0;
    i2c_push = 1'b0;
    i2c_byte = sreg_q;
    if (!i2c_mode) begin
      st_d = ISB_ST_IDLE;
      drv_d = 1'b0;
    end else if (start_c) begin
      // first or repeated start both reopen the address phase
      st_d = ISB_ST_ADDR;
      cnt_d = 4'h0;
      drv_d = 1'b0;
    end else if (stop_c) begin
      st_d = ISB_ST_IDLE;
      drv_d = 1'b0;
    end else begin
      unique case (st_q)
        ISB_ST_IDLE: begin
          drv_d = 1'b0;
        end
        ISB_ST_ADDR: begin
          if (scl_r) begin
            sreg_d = {sreg_q[6:0], pin_q[1]};
            cnt_d = cnt_q + 4'h1;
          end else if (scl_f && cnt_q == 4'h8) begin
            // address then direction bit, as the master sends it
            if (sreg_q[7:1] == cfg_in.slave_addr || sreg_q[7:1] == cfg_in.nvm_addr) begin
              drv_d = 1'b1;
              rw_d = sreg_q[0];
              nvm_d = (sreg_q[7:1] == cfg_in.nvm_addr);
              st_d = ISB_ST_ADDR_ACK;
            end else begin
              st_d = ISB_ST_IDLE;
            end
          end
        end
        ISB_ST_ADDR_ACK: begin
          if (scl_f) begin
            if (rw_q) begin
              // transmit: first byte msb out right after the ack
              sreg_d = next_byte;
              i2c_pop = rx_valid & ~nvm_q;
              drv_d = ~next_byte[7];
              cnt_d = 4'h1;
              st_d = ISB_ST_RD_DATA;
            end else begin
              drv_d = 1'b0;
              cnt_d = 4'h0;
              st_d = ISB_ST_WR_DATA;
            end
          end
        end
        ISB_ST_WR_DATA: begin
          if (scl_r) begin
            sreg_d = {sreg_q[6:0], pin_q[1]};
            cnt_d = cnt_q + 4'h1;
          end else if (scl_f && cnt_q == 4'h8) begin
            st_d = ISB_ST_WR_ACK;
            if (nvm_q) begin
              nvm_v_d = 1'b1;
              nvm_data_d = sreg_q;
              drv_d = 1'b1;
            end else begin
              // a full buffer drops the byte and is not acknowledged
              i2c_push = tx_ready;
              drv_d = tx_ready;
            end
          end
        end
        ISB_ST_WR_ACK: begin
          if (scl_f) begin
            drv_d = 1'b0;
            cnt_d = 4'h0;
            st_d = ISB_ST_WR_DATA;
          end
        end
        ISB_ST_RD_DATA: begin
          if (scl_f) begin
            if (cnt_q == 4'h8) begin
              drv_d = 1'b0;
              st_d = ISB_ST_RD_ACK;
            end else begin
              sreg_d = {sreg_q[6:0], 1'b0};
              drv_d = ~sreg_q[6];
              cnt_d = cnt_q + 4'h1;
            end
          end
        end
        ISB_ST_RD_ACK: begin
          if (scl_r) begin
            ack_d = ~pin_q[1];
          end else if (scl_f) begin
            if (ack_q) begin
              sreg_d = next_byte;
              i2c_pop = rx_valid & ~nvm_q;
              drv_d = ~next_byte[7];
              cnt_d = 4'h1;
              st_d = ISB_ST_RD_DATA;
            end else begin
              st_d = ISB_ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // slave state registers
  always_ff @(posedge clk_in) begin
    if (rst_all) begin
      st_q <= ISB_ST_IDLE;
      cnt_q <= 4'h0;
      sreg_q <= 8'h00;
      rw_q <= 1'b0;
      nvm_q <= 1'b0;
      ack_q <= 1'b0;
      drv_q <= 1'b0;
      nvm_wr_valid_out <= 1'b0;
      nvm_wr_data_out <= 8'h00;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sreg_q <= sreg_d;
      rw_q <= rw_d;
      nvm_q <= nvm_d;
      ack_q <= ack_d;
      drv_q <= drv_d;
      nvm_wr_valid_out <= nvm_v_d;
      nvm_wr_data_out <= nvm_data_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // bit-bang port, rate timer and pin drivers
  logic [15:0] div_q, div_d; // rate timer
  logic [1:0] port_q, port_d, dir_d; // port value and direction
  logic wr_n_d, rd_n_d, tick;
  logic scl_out_d, scl_oe_d, sda_out_d, sda_oe_d;

  always_comb begin
    tick = (div_q == 16'h0000);
    div_d = (tick || i2c_mode) ? cfg_in.bb_div : div_q - 16'h0001;
    port_d = port_q;
    dir_d = cfg_in.bb_dir;
    wr_n_d = 1'b1;
    rd_n_d = 1'b1;
    bb_pop = 1'b0;
    bb_push = 1'b0;
    bb_byte = {6'h00, pin_q[1:0]};
    if (!i2c_mode && tick) begin
      if (rx_valid) begin
        // one byte per tick, low two bits onto the port
        bb_pop = 1'b1;
        port_d = rx_data[1:0];
        wr_n_d = 1'b0;
      end
      // sync mode reads only alongside a write; async reads every tick
      if (cfg_in.mode == ISB_MODE_ASYNC_BB || rx_valid) begin
        bb_push = tx_ready;
        rd_n_d = ~tx_ready;
      end
    end
    if (i2c_mode) begin
      scl_out_d = 1'b0;
      scl_oe_d = 1'b0;
      sda_out_d = 1'b0;
      sda_oe_d = drv_d;
    end else begin
      scl_out_d = port_d[0];
      scl_oe_d = dir_d[0];
      sda_out_d = port_d[1];
      sda_oe_d = dir_d[1];
    end
  end

  // port registers
  always_ff @(posedge clk_in) begin
    if (rst_all) begin
      div_q <= 16'h0000;
      port_q <= 2'h3;
      scl_out <= 1'b0;
      scl_oe_out <= 1'b0;
      sda_out <= 1'b0;
      sda_oe_out <= 1'b0;
    end else begin
      div_q <= div_d;
      port_q <= port_d;
      scl_out <= scl_out_d;
      scl_oe_out <= scl_oe_d;
      sda_out <= sda_out_d;
      sda_oe_out <= sda_oe_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // reference clock divider and auxiliary pin
  logic [7:0] ref_cnt_q, ref_cnt_d, half;
  logic ref_q, ref_d, aux_d, aux_oe_d;

  always_comb begin
    unique case (cfg_in.clk_sel)
      2'b00: half = HALF48;
      2'b01: half = HALF24;
      2'b10: half = HALF12;
      2'b11: half = HALF6;
    endcase
    ref_d = ref_q;
    ref_cnt_d = ref_cnt_q + 8'h01;
    if (ref_cnt_q + 8'h01 >= half) begin
      ref_cnt_d = 8'h00;
      ref_d = ~ref_q;
    end
    aux_oe_d = 1'b1;
    unique case (cfg_in.aux_func)
      ISB_AUX_TRISTATE: begin
        aux_d = 1'b0;
        aux_oe_d = 1'b0;
      end
      ISB_AUX_DRIVE1: aux_d = 1'b1;
      ISB_AUX_DRIVE0: aux_d = 1'b0;
      ISB_AUX_CLK: aux_d = ref_d;
      ISB_AUX_BB_WR_N: aux_d = wr_n_d;
      ISB_AUX_BB_RD_N: aux_d = rd_n_d;
      ISB_AUX_TXE_N: aux_d = host_in_valid_out;
      ISB_AUX_RXF_N: aux_d = ~rx_valid;
    endcase
  end

  // aux registers; drive strength follows the stored setting
  always_ff @(posedge clk_in) begin
    if (rst_all) begin
      ref_cnt_q <= 8'h00;
      ref_q <= 1'b0;
      aux_control_pin_out <= 1'b0;
      aux_control_pin_oe_out <= 1'b0;
      aux_drive_out <= 2'h0;
    end else begin
      ref_cnt_q <= ref_cnt_d;
      ref_q <= ref_d;
      aux_control_pin_out <= aux_d;
      aux_control_pin_oe_out <= aux_oe_d;
      aux_drive_out <= cfg_in.aux_drive;
    end
  end
endmodule : isb_bridge

// ---- tb/isb_bridge_monitor.sv ----
// checker of the bridge top ports, bound to every isb_bridge instance.
// assumes a single clk_in domain with rst_in synchronous, active high.
`timescale 1ns/1ps
module isb_bridge_monitor
  import isb_pkg::*;
(
  // clock and resets
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic rst_n_pin_in,
  // configuration and bus pins
  input wire isb_pkg::isb_cfg_t cfg_in,
  input wire logic scl_in,
  input wire logic scl_oe_out,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  // aux pin and streams
  input wire logic aux_control_pin_out,
  input wire logic [1:0] aux_drive_out,
  input wire logic host_out_ready_out,
  input wire logic host_in_valid_out,
  input wire logic [7:0] host_in_data_out,
  input wire logic host_in_ready_in,
  input wire logic nvm_wr_valid_out
);
  //////////////////////////////////////////////////////////////////////////////
  // a slave never drives or stretches the clock line
  scl_never_driven_a: assert property (@(posedge clk_in) disable iff (rst_in)
    cfg_in.mode == ISB_MODE_I2C |-> !scl_oe_out) else $error("clock line driven");
  // open drain: the data line is only ever pulled low
  sda_open_drain_a: assert property (@(posedge clk_in) disable iff (rst_in)
    cfg_in.mode == ISB_MODE_I2C && sda_oe_out |-> !sda_out) else $error("data driven high");
  // the slave moves data only while the clock is low, so no false start or stop
  sda_moves_low_a: assert property (@(posedge clk_in) disable iff (rst_in)
    cfg_in.mode == ISB_MODE_I2C && $changed(sda_oe_out) |-> !scl_in)
    else $error("data moved with clock high");
  // reset leaves data drive, both stream handshakes and config write quiet one edge later
  reset_quiet_a: assert property (@(posedge clk_in)
    rst_in |=> !sda_oe_out && !host_in_valid_out && !nvm_wr_valid_out && !host_out_ready_out)
    else $error("outputs active in reset");
  // empty buffer accepts host bytes right after reset
  ready_after_reset_a: assert property (@(posedge clk_in)
    $fell(rst_in) && rst_n_pin_in |=> host_out_ready_out) else $error("not ready after reset");
  // config store write is a single-cycle pulse
  nvm_pulse_a: assert property (@(posedge clk_in) disable iff (rst_in)
    nvm_wr_valid_out |=> !nvm_wr_valid_out) else $error("config write pulse too long");
  // drive strength follows the stored setting
  aux_drive_copy_a: assert property (@(posedge clk_in) disable iff (rst_in)
    $stable(cfg_in) && !$past(rst_in) && $past(rst_n_pin_in, 5) |->
    aux_drive_out == cfg_in.aux_drive)
    else $error("drive strength wrong");
  // a stalled byte toward the host holds still
  host_in_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
    host_in_valid_out && !host_in_ready_in |=> host_in_valid_out && $stable(host_in_data_out))
    else $error("host byte changed while stalled");
  // write strobe of the port is low for exactly one cycle
  strobe_one_cycle_a: assert property (@(posedge clk_in) disable iff (rst_in)
    cfg_in.mode != ISB_MODE_I2C && cfg_in.aux_func == ISB_AUX_BB_WR_N
    && $fell(aux_control_pin_out) |=> aux_control_pin_out) else $error("strobe too long");
endmodule : isb_bridge_monitor

bind isb_bridge isb_bridge_monitor mon (
  .clk_in(clk_in), .rst_in(rst_in), .rst_n_pin_in(rst_n_pin_in), .cfg_in(cfg_in),
  .scl_in(scl_in), .scl_oe_out(scl_oe_out), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
  .aux_control_pin_out(aux_control_pin_out), .aux_drive_out(aux_drive_out),
  .host_out_ready_out(host_out_ready_out), .host_in_valid_out(host_in_valid_out),
  .host_in_data_out(host_in_data_out), .host_in_ready_in(host_in_ready_in),
  .nvm_wr_valid_out(nvm_wr_valid_out)
);

// ---- tb/isb_master.sv ----
// two-wire bus master model driving the bridge as the far party.
// assumes the bench resolves the open-drain lines with pull-ups.
`timescale 1ns/1ps
module isb_master #(
  parameter int HALF = 16
) (
  // clock
  input wire logic clk_in,
  // resolved bus levels
  input wire logic scl_in,
  input wire logic sda_in,
  // high pulls the line low
  output logic scl_low_out,
  output logic sda_low_out
);
  // released at time zero, clock stands high outside frames
  initial begin
    scl_low_out = 1'b0;
    sda_low_out = 1'b0;
  end
  task automatic gap(input int n);
    repeat (n) @(posedge clk_in);
  endtask : gap
  // start or repeated start; data moves mid-low to keep clear of the clock edge
  task automatic start();
    gap(HALF / 2);
    sda_low_out <= 1'b0;
    gap(HALF / 2);
    scl_low_out <= 1'b0;
    gap(HALF);
    sda_low_out <= 1'b1;
    gap(HALF);
    scl_low_out <= 1'b1;
  endtask : start
  task automatic stop();
    gap(HALF / 2);
    sda_low_out <= 1'b1;
    gap(HALF / 2);
    scl_low_out <= 1'b0;
    gap(HALF);
    sda_low_out <= 1'b0;
    gap(HALF);
  endtask : stop
  // one clock pulse: drive b, sample the line at the end of the high time
  task automatic bit_io(input logic b, output logic r);
    gap(HALF / 2);
    sda_low_out <= !b;
    gap(HALF / 2);
    scl_low_out <= 1'b0;
    gap(HALF);
    r = sda_in;
    scl_low_out <= 1'b1;
  endtask : bit_io
  // byte out msb first, ack bit returned
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, ack);
  endtask : wbyte
  // byte in msb first, ack all but the last
  task automatic rbyte(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      b[i] = r;
    end
    bit_io(last, r);
  endtask : rbyte
endmodule : isb_master

// ---- tb/isb_bridge_bench.sv ----
// self-checking bench for isb_bridge: bus master model, host streams.
// assumes isb_master.sv and the bound checker are compiled beside it.
`timescale 1ns/1ps
module isb_bridge_bench;
  import isb_pkg::*;
  localparam logic [6:0] SLV = 7'h2A; // data address
  localparam logic [6:0] NVM = 7'h51; // config store address
  localparam int DIV = 5; // bit-bang pacing setting
  logic clk_in;
  logic rst_in = 1'b1;
  logic rst_n_pin = 1'b1;
  isb_cfg_t cfg = '0;
  logic scl_out, scl_oe, sda_out, sda_oe, aux, aux_oe, ho_ready, hi_valid, nvm_v;
  logic [1:0] aux_drv;
  logic ho_valid = 1'b0;
  logic hi_ready = 1'b0;
  logic [7:0] ho_data = 8'h00;
  logic [7:0] hi_data, nvm_d, nvm_last;
  logic m_scl_low, m_sda_low;
  int num_errors = 0;
  int checked = 0;
  int nvm_cnt = 0;
  logic [31:0] seed = 32'h16DE9AC5;
  // pull-ups on both lines, port pins push-pull in bit-bang
  wire scl_w = (scl_oe ? scl_out : 1'b1) & !m_scl_low;
  wire sda_w = (sda_oe ? sda_out : 1'b1) & !m_sda_low;

  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  isb_bridge uut (
    .clk_in(clk_in), .rst_in(rst_in), .rst_n_pin_in(rst_n_pin), .cfg_in(cfg),
    .scl_in(scl_w), .scl_out(scl_out), .scl_oe_out(scl_oe), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe_out(sda_oe), .aux_control_pin_out(aux),
    .aux_control_pin_oe_out(aux_oe), .aux_drive_out(aux_drv), .host_out_valid_in(ho_valid),
    .host_out_data_in(ho_data), .host_out_ready_out(ho_ready), .host_in_valid_out(hi_valid),
    .host_in_data_out(hi_data), .host_in_ready_in(hi_ready), .nvm_wr_valid_out(nvm_v),
    .nvm_wr_data_out(nvm_d)
  );
  isb_master m (
    .clk_in(clk_in), .scl_in(scl_w), .sda_in(sda_w),
    .scl_low_out(m_scl_low), .sda_low_out(m_sda_low)
  );
  // config store writes are counted as they pass
  always @(posedge clk_in) begin
    if (nvm_v === 1'b1) begin
      nvm_cnt <= nvm_cnt + 1;
      nvm_last <= nvm_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [7:0] addr_byte(input logic [6:0] a, input logic rd);
    return {a, rd};
  endfunction : addr_byte
  // port level expected from a byte: low two bits only
  function automatic logic [7:0] pin_pair(input logic [7:0] b);
    return {6'h00, b[1:0]};
  endfunction : pin_pair
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // valid stays up between bytes; caller lowers it
  task automatic push(input logic [7:0] b);
    ho_valid <= 1'b1;
    ho_data <= b;
    for (int k = 0; k < 50; k++) begin
      @(posedge clk_in);
      if (ho_ready === 1'b1) break;
    end
  endtask : push
  // spare edge parts ready drop and raise
  task automatic pop(output logic [7:0] b);
    b = 'x;
    @(posedge clk_in);
    hi_ready <= 1'b1;
    for (int k = 0; k < 50; k++) begin
      @(posedge clk_in);
      if (hi_valid === 1'b1) begin
        b = hi_data;
        break;
      end
    end
    hi_ready <= 1'b0;
  endtask : pop
  task automatic set_mode(input isb_mode_t md, input isb_aux_t af);
    isb_cfg_t c;
    c = cfg;
    c.mode = md;
    c.aux_func = af;
    c.slave_addr = SLV;
    c.nvm_addr = NVM;
    c.aux_drive = 2'(rnd());
    c.clk_sel = 2'(rnd());
    c.bb_dir = 2'b11;
    c.bb_div = 16'(DIV);
    @(posedge clk_in);
    rst_in <= 1'b1;
    cfg <= c;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (2) @(posedge clk_in);
  endtask : set_mode
  // bounded wait for the write strobe; t counts the idle cycles before it
  task automatic strobe(output int t);
    for (t = 0; t < 200; t++) begin
      @(posedge clk_in);
      if (aux === 1'b0) break;
    end
  endtask : strobe
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] q[$];
    logic [7:0] b;
    logic a;
    int n;
    int t;
    set_mode(ISB_MODE_I2C, ISB_AUX_TXE_N);
    chk("out ready", 16'(ho_ready), 16'h0001);
    chk("txe idle", 16'(aux), 16'h0000);
    chk("aux oe", 16'(aux_oe), 16'h0001);
    n = 2 + int'(rnd() % 3);
    m.start();
    m.wbyte(addr_byte(SLV, 1'b0), a);
    chk("addr ack", 16'(a), 16'h0000);
    for (int k = 0; k < n; k++) begin
      b = 8'(rnd());
      q.push_back(b);
      m.wbyte(b, a);
      chk("data ack", 16'(a), 16'h0000);
    end
    m.stop();
    chk("txe filled", 16'(aux), 16'h0001);
    foreach (q[k]) begin
      pop(b);
      chk("in byte", 16'(b), 16'(q[k]));
    end
    repeat (8) @(posedge clk_in);
    chk("txe drained", 16'(aux), 16'h0000);
    m.start();
    m.wbyte(addr_byte(SLV ^ 7'h01, 1'b0), a);
    chk("foreign nack", 16'(a), 16'h0001);
    m.stop();
    $display("test write done");
    q.delete();
    for (int k = 0; k < n; k++) begin
      b = 8'(rnd());
      q.push_back(b);
      push(b);
    end
    ho_valid <= 1'b0;
    m.start();
    m.wbyte(addr_byte(SLV, 1'b0), a);
    m.start();
    m.wbyte(addr_byte(SLV, 1'b1), a);
    chk("reread ack", 16'(a), 16'h0000);
    foreach (q[k]) begin
      m.rbyte(k == n - 1, b);
      chk("read byte", 16'(b), 16'(q[k]));
    end
    m.stop();
    m.start();
    m.wbyte(addr_byte(SLV, 1'b1), a);
    m.rbyte(1'b1, b);
    m.stop();
    chk("empty read", 16'(b), 16'(IDLE_BYTE));
    $display("test read done");
    m.start();
    m.wbyte(addr_byte(NVM, 1'b0), a);
    b = 8'(rnd());
    m.wbyte(b, a);
    m.stop();
    chk("nvm count", 16'(nvm_cnt), 16'h0001);
    chk("nvm byte", 16'(nvm_last), 16'(b));
    rst_n_pin <= 1'b0;
    repeat (10) @(posedge clk_in);
    chk("pin reset", 16'(ho_ready), 16'h0000);
    rst_n_pin <= 1'b1;
    repeat (10) @(posedge clk_in);
    chk("pin release", 16'(ho_ready), 16'h0001);
    $display("test config done");
    set_mode(ISB_MODE_ASYNC_BB, ISB_AUX_BB_WR_N);
    fork
      begin
        foreach (q[k]) push(q[k]);
        ho_valid <= 1'b0;
      end
      foreach (q[k]) begin
        strobe(t);
        chk("port", {14'h0000, sda_w, scl_w}, 16'(pin_pair(q[k])));
        if (k > 0) chk("pace", 16'(t + 1), 16'(DIV + 1));
      end
    join
    $display("test async done");
    set_mode(ISB_MODE_SYNC_BB, ISB_AUX_RXF_N);
    repeat (40) @(posedge clk_in);
    chk("sync idle", 16'(hi_valid), 16'h0000);
    chk("rxf idle", 16'(aux), 16'h0001);
    foreach (q[k]) push(q[k]);
    ho_valid <= 1'b0;
    @(posedge clk_in);
    chk("rxf held", 16'(aux), 16'h0000);
    repeat (n * (DIV + 1) + 20) @(posedge clk_in);
    pop(b);
    for (int k = 1; k < n; k++) begin
      pop(b);
      chk("sync sample", 16'(b), 16'(pin_pair(q[k - 1])));
    end
    repeat (4) @(posedge clk_in);
    chk("sync count", 16'(hi_valid), 16'h0000);
    $display("test sync done");
    end_of_test();
  end
  // cut a hang short
  initial begin
    repeat (60000) @(posedge clk_in);
    num_errors++;
    end_of_test();
  end
endmodule : isb_bridge_bench
